// ### rtl/uart_rx_buffer.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`include "uart_rx_map.svh"
`default_nettype none
// Notes on behaviour
// [R1] Nine-bit mode: software reads the ninth bit from B before data.
// [R2] Each data read advances the buffer; ninth bit and flags follow.
// [R3] Software reads A flags before reading that frame's data.
// [R4] Receive-complete reads one while any unread frame remains.
// [R5] Clearing receiver enable empties the buffer; receive-complete drops.
// [R6] Interrupt requested while enabled and receive-complete set, gated globally.
// [R7] Error flags stored with their frame, shown for the head frame.
// [R8] Writes to A never change the three error flags.
// [R9] Software writes zeros to the error flag positions of A.
// [R10] Error flags raise no interrupt of their own.
// [R11] Frame error is one when the first stop bit sampled low.
// [R12] Only the first stop bit is checked, whatever stop count says.
// [R13] Overrun: buffer full, frame waiting, new start seen; that frame lost.
// [R14] Overrun clears when a frame moves into the buffer.
// [R15] Parity checked only while parity enable is set.
// [R16] Parity over data compared with parity bit, result stored in entry.
// [R17] Parity error only if checking was on at reception; valid until read.
// [R18] Parity error reads zero while checking is disabled.
// [R19] Receiver disable acts at once, abandoning a reception.
// [R20] Disabled receiver releases the serial input pin.
// [R21] Start bit begins reception; frame moves to buffer at first stop bit.
// [R22] Unused upper data bits of short characters read zero.
// [R23] Receiver enable in B enables receiver and takes the pin.
// [R24] Odd select zero means even parity, one means odd.
// [R25] Ninth data bit appears at B bit one for the head entry.
module uart_rx_buffer
    import uart_rx_pkg::*;
#(
    parameter int CLKS_PER_BIT = `RX_BIT_CLKS,
    parameter int DEPTH = `RX_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic serial_input_pin,
    input wire logic global_irq_enable,
    output logic rx_irq,
    output logic pin_override
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic irq_en;
        logic rx_enable;
        logic par_en;
        logic par_odd;
        logic stop2;
        logic [2:0] size;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic hold_valid;
        frame_s hold;
        logic dor_pending;
        logic drop_next;
        logic [7:0] rdata;
        logic irq;
    } buffer_s;

    buffer_s s_reg;
    buffer_s s_next;
    entry_s head;
    entry_s push_entry;
    frame_s frame_in;
    logic start_in;
    logic done_in;
    logic rxc;
    logic push;
    logic pop;
    logic space;
    logic overrun;
    logic [7:0] rd_value;

    ////////////////////////////////////////////////////////////////////////////
    // Receive shifter and entry store

    // Character reception from the pin
    rx_frame_shifter #(
        .CLKS_PER_BIT(CLKS_PER_BIT)
    ) shifter (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .rx_on(s_reg.rx_enable),
        .serial_in(serial_input_pin),
        .n_bits(char_bits(s_reg.size)),
        .parity_en(s_reg.par_en),
        .parity_odd(s_reg.par_odd),
        .start_seen(start_in),
        .done(done_in),
        .frame(frame_in)
    );

    // Two-entry buffer storage, read at the next head
    rx_entry_store #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) store (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .we(push),
        .waddr(s_reg.wr_ptr),
        .wentry(push_entry),
        .raddr(s_next.rd_ptr),
        .rentry(head)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_next = s_reg;
        push = 1'b0;
        pop = 1'b0;
        overrun = 1'b0;
        push_entry = '0;
        rd_value = '0;
        rxc = (s_reg.count != '0); // see [R4]

        // Register writes; A and data writes leave the flags alone
        if (wr) begin
            unique case (addr)
                `ADDR_CSA: begin
                    s_next.irq_en = s_reg.irq_en; // see [R8]
                end
                `ADDR_CSB: begin
                    s_next.irq_en = wdata[`CSB_RXCIE_BIT];
                    s_next.rx_enable = wdata[`CSB_RXEN_BIT]; // see [R23]
                end
                `ADDR_CSC: begin
                    s_next.par_en = wdata[`CSC_PAR_EN_BIT];
                    s_next.par_odd = wdata[`CSC_PAR_ODD_BIT];
                    s_next.stop2 = wdata[`CSC_STOP2_BIT];
                    s_next.size = wdata[`CSC_SIZE_LSB +: 3];
                end
                `ADDR_DATA: begin
                    s_next.size = s_reg.size;
                end
            endcase
        end

        // Read value; A flags and ninth bit shown for the head entry only while it is unread
        unique case (addr)
            `ADDR_CSA: begin
                rd_value[`CSA_RXC_BIT] = rxc;
                rd_value[`CSA_FE_BIT] = rxc & head.frame.fe; // see [R7]
                rd_value[`CSA_DOR_BIT] = rxc & head.dor;
                rd_value[`CSA_PE_BIT] = rxc & head.frame.perr & s_reg.par_en; // see [R18]
            end
            `ADDR_CSB: begin
                rd_value[`CSB_RXCIE_BIT] = s_reg.irq_en;
                rd_value[`CSB_RXEN_BIT] = s_reg.rx_enable;
                rd_value[`CSB_RX9_BIT] = rxc & head.frame.data[8]; // see [R25]
            end
            `ADDR_CSC: begin
                rd_value[`CSC_PAR_EN_BIT] = s_reg.par_en;
                rd_value[`CSC_PAR_ODD_BIT] = s_reg.par_odd;
                rd_value[`CSC_STOP2_BIT] = s_reg.stop2;
                rd_value[`CSC_SIZE_LSB +: 3] = s_reg.size;
            end
            `ADDR_DATA: begin
                rd_value = head.frame.data[7:0];
            end
        endcase
        s_next.rdata = rd ? rd_value : 8'h00;

        // Data read advances the head
        pop = rd && addr == `ADDR_DATA && rxc && s_reg.rx_enable; // see [R2]
        space = (s_reg.count != FULL_COUNT) || pop;

        if (s_reg.rx_enable) begin
            // Waiting character moves in as soon as room opens
            if (s_reg.hold_valid && space) begin
                push = 1'b1;
                push_entry.frame = s_reg.hold;
                push_entry.dor = s_reg.dor_pending;
                s_next.hold_valid = 1'b0;
            end
            // New character: lost after overrun, else buffered or held
            if (done_in) begin
                if (s_reg.drop_next) begin
                    s_next.drop_next = 1'b0; // see [R13]
                end else if (!s_reg.hold_valid && space) begin
                    push = 1'b1; // see [R21]
                    push_entry.frame = frame_in;
                    push_entry.dor = s_reg.dor_pending;
                end else begin
                    s_next.hold = frame_in;
                    s_next.hold_valid = 1'b1;
                end
            end
            if (push) begin
                s_next.dor_pending = 1'b0; // see [R14]
            end
            // Set wins over the clear above
            if (start_in && s_reg.hold_valid && !space) begin
                overrun = 1'b1;
                s_next.dor_pending = 1'b1; // see [R13]
                s_next.drop_next = 1'b1;
            end
            s_next.wr_ptr = push ? AW'(s_reg.wr_ptr + 1'b1) : s_reg.wr_ptr;
            s_next.rd_ptr = pop ? AW'(s_reg.rd_ptr + 1'b1) : s_reg.rd_ptr;
            s_next.count = s_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
        end else begin
            // Disabled: everything stored is discarded
            s_next.count = '0; // see [R5]
            s_next.rd_ptr = s_reg.wr_ptr;
            s_next.hold_valid = 1'b0;
            s_next.dor_pending = 1'b0;
            s_next.drop_next = 1'b0;
        end

        // Only receive-complete requests the interrupt
        s_next.irq = s_reg.irq_en && rxc && global_irq_enable; // see [R6] see [R10]
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.size <= `CSC_SIZE_RESET;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign rx_irq = s_reg.irq;
    assign pin_override = s_reg.rx_enable; // see [R20]

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    chk_rxc_reads_count: assert property ( // see [R4]
        ce && rd && addr == `ADDR_CSA |=> rdata[`CSA_RXC_BIT] == ($past(s_reg.count) != '0))
        else $error("receive-complete does not match buffer fill");
    chk_flush_disable: assert property ( // see [R5]
        ce && !s_reg.rx_enable |=> s_reg.count == '0 && !s_reg.hold_valid ##1 !rx_irq || !ce)
        else $error("buffer not flushed while disabled");
    chk_read_advances: assert property ( // see [R2]
        ce && pop |=> s_reg.rd_ptr != $past(s_reg.rd_ptr)
            && s_reg.count == $past(s_reg.count) - $past(push ? 2'h0 : 2'h1))
        else $error("data read did not advance buffer");
    chk_irq_level: assert property ( // see [R6]
        ce |=> rx_irq == $past(s_reg.irq_en && s_reg.count != '0 && global_irq_enable))
        else $error("interrupt request wrong");
    chk_err_no_irq: assert property ( // see [R10]
        ce && s_reg.count == '0 |=> !rx_irq)
        else $error("interrupt without unread data");
    chk_a_write_safe: assert property ( // see [R8]
        ce && wr && addr == `ADDR_CSA && !pop && s_reg.count != '0 |=> head == $past(head))
        else $error("write to A changed the head flags");
    chk_pe_off_zero: assert property ( // see [R18]
        ce && rd && addr == `ADDR_CSA && !s_reg.par_en |=> !rdata[`CSA_PE_BIT])
        else $error("parity error shown while checking off");
    chk_dor_clear: assert property ( // see [R14]
        ce && push && !overrun |=> !s_reg.dor_pending)
        else $error("overrun not cleared on transfer");
    chk_overrun_set: assert property ( // see [R13]
        ce && overrun |=> s_reg.dor_pending && s_reg.drop_next)
        else $error("overrun not recorded");
    chk_pin_handover: assert property ( // see [R23]
        ce && wr && addr == `ADDR_CSB |=> pin_override == $past(wdata[`CSB_RXEN_BIT]))
        else $error("pin override not following enable");

    cov_frame_stored: cover property (ce && push ##1 rxc);
    cov_buffer_full: cover property (ce && s_reg.hold_valid && s_reg.count == FULL_COUNT);
    cov_overrun: cover property (ce && overrun);
    cov_irq_raised: cover property (!rx_irq ##1 rx_irq);
endmodule
`default_nettype wire

// ### shared/uart_rx_map.svh
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH

// Register offsets on the plain register port
`define ADDR_CSA 2'h0
`define ADDR_CSB 2'h1
`define ADDR_CSC 2'h2
`define ADDR_DATA 2'h3

// Control/status A bit positions
`define CSA_RXC_BIT 7
`define CSA_FE_BIT 4
`define CSA_DOR_BIT 3
`define CSA_PE_BIT 2

// Control/status B bit positions
`define CSB_RXCIE_BIT 7
`define CSB_RXEN_BIT 4
`define CSB_RX9_BIT 1

// Control/status C bit positions
`define CSC_PAR_EN_BIT 5
`define CSC_PAR_ODD_BIT 4
`define CSC_STOP2_BIT 3
`define CSC_SIZE_LSB 0

// Character size codes and reset value
`define SIZE_NINE 3'h7
`define SIZE_BASE_BITS 4'h5
`define CSC_SIZE_RESET 3'h3

// Buffer depth and bit timing
`define RX_FIFO_DEPTH 2
`define CLOCK_HZ 50000000
`define BAUD_RATE 115200
`define RX_BIT_CLKS (`CLOCK_HZ / `BAUD_RATE)

`endif

// ### shared/uart_rx_pkg.sv
`include "uart_rx_map.svh"
`default_nettype none
package uart_rx_pkg;

    // Receiver sequence, Gray coded along the frame
    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h3,
        RX_PARITY = 3'h2,
        RX_STOP = 3'h6
    } rx_state_e;

    // One received character with its own status
    typedef struct packed {
        logic [8:0] data;
        logic fe;
        logic perr;
    } frame_s;

    // One buffer entry
    typedef struct packed {
        frame_s frame;
        logic dor;
    } entry_s;

    // Data bits per character from the size code
    function automatic logic [3:0] char_bits(input logic [2:0] size);
        char_bits = (size == `SIZE_NINE) ? 4'h9 : (`SIZE_BASE_BITS + {2'h0, size[1:0]});
    endfunction

endpackage
`default_nettype wire

// ### rtl/rx_entry_store.sv
`include "uart_rx_map.svh"
`default_nettype none
module rx_entry_store
    import uart_rx_pkg::*;
#(
    parameter int DEPTH = `RX_FIFO_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire entry_s wentry,
    input wire logic [AW-1:0] raddr,
    output entry_s rentry
);
    typedef struct packed {
        entry_s [DEPTH-1:0] mem;
        entry_s rdata;
    } store_s;

    store_s s_reg;
    store_s s_next;

    // Write first, so a fresh entry reads through at once
    always_comb begin
        s_next = s_reg;
        if (we) begin
            s_next.mem[waddr] = wentry;
        end
        s_next.rdata = s_next.mem[raddr];
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign rentry = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_write_lands: assert property (@(posedge clock) disable iff (!rst_b) // see [R7]
        ce && we && raddr == waddr |=> rentry == $past(wentry))
        else $error("stored entry not presented");
endmodule
`default_nettype wire

// ### rtl/rx_frame_shifter.sv
`include "uart_rx_map.svh"
`default_nettype none
module rx_frame_shifter
    import uart_rx_pkg::*;
#(
    parameter int CLKS_PER_BIT = `RX_BIT_CLKS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic rx_on,
    input wire logic serial_in,
    input wire logic [3:0] n_bits,
    input wire logic parity_en,
    input wire logic parity_odd,
    output logic start_seen,
    output logic done,
    output frame_s frame
);
    localparam logic [15:0] FULL_CNT = 16'(CLKS_PER_BIT - 1);
    localparam logic [15:0] HALF_CNT = 16'(CLKS_PER_BIT / 2 - 1);

    typedef struct packed {
        rx_state_e st;
        logic [15:0] cnt;
        logic [3:0] idx;
        logic [8:0] data;
        logic par;
        logic start_seen;
        logic done;
        frame_s frame;
    } shifter_s;

    shifter_s s_reg;
    shifter_s s_next;

    // Frame sequence, sampled at mid bit
    always_comb begin
        s_next = s_reg;
        s_next.start_seen = 1'b0;
        s_next.done = 1'b0;
        if (!rx_on) begin
            s_next.st = RX_IDLE; // see [R19]
            s_next.cnt = '0;
        end else if (s_reg.cnt != '0 && s_reg.st != RX_IDLE) begin
            s_next.cnt = s_reg.cnt - 16'h0001;
        end else begin
            unique case (s_reg.st)
                RX_IDLE: begin
                    if (!serial_in) begin
                        s_next.st = RX_START;
                        s_next.cnt = HALF_CNT;
                    end
                end
                RX_START: begin
                    // Start still low at mid bit: valid start
                    if (serial_in) begin
                        s_next.st = RX_IDLE;
                    end else begin
                        s_next.st = RX_DATA; // see [R21]
                        s_next.cnt = FULL_CNT;
                        s_next.idx = '0;
                        s_next.data = '0; // see [R22]
                        s_next.par = 1'b0;
                        s_next.start_seen = 1'b1;
                    end
                end
                RX_DATA: begin
                    s_next.data[s_reg.idx] = serial_in;
                    s_next.par = s_reg.par ^ serial_in; // see [R16]
                    s_next.cnt = FULL_CNT;
                    if (s_reg.idx == 4'(n_bits - 4'h1)) begin
                        s_next.st = parity_en ? RX_PARITY : RX_STOP; // see [R15]
                    end else begin
                        s_next.idx = s_reg.idx + 4'h1;
                    end
                end
                RX_PARITY: begin
                    // Mismatch is one; odd select inverts the expectation
                    s_next.par = s_reg.par ^ serial_in ^ parity_odd; // see [R24]
                    s_next.cnt = FULL_CNT;
                    s_next.st = RX_STOP;
                end
                RX_STOP: begin
                    // Only the first stop bit is looked at
                    s_next.frame.data = s_reg.data;
                    s_next.frame.fe = !serial_in; // see [R11] see [R12]
                    s_next.frame.perr = parity_en & s_reg.par; // see [R17]
                    s_next.done = 1'b1;
                    s_next.st = RX_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign start_seen = s_reg.start_seen;
    assign done = s_reg.done;
    assign frame = s_reg.frame;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_abort_on_off: assert property (@(posedge clock) disable iff (!rst_b) // see [R19]
        ce && !rx_on |=> s_reg.st == RX_IDLE && !done)
        else $error("reception not abandoned");
    chk_stop_sample_fe: assert property (@(posedge clock) disable iff (!rst_b) // see [R11]
        ce && rx_on && s_reg.st == RX_STOP && s_reg.cnt == '0 |=> done && frame.fe == !$past(serial_in))
        else $error("frame error not from stop bit");
endmodule
`default_nettype wire

// ### sim/uart_tx_model.sv
`default_nettype none
module uart_tx_model #(
    parameter int CLKS = 8
) (
    input wire logic clock,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;

    // Line idles high between frames
    initial line = 1'b1;

    // One bit held for a full bit time
    task automatic put_bit(input logic b);
        line <= b;
        repeat (CLKS) @(posedge clock);
    endtask

    // Start, data LSB first, optional parity, one stop bit
    task automatic send(input logic [8:0] d, input int n, input logic pen, input logic pbit, input logic stop);
        @(posedge clock);
        put_bit(1'b0);
        for (int i = 0; i < n; i++) begin
            put_bit(d[i]);
        end
        if (pen) begin
            put_bit(pbit);
        end
        put_bit(stop);
        line <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
`include "uart_rx_map.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0;
    logic rst_b;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic serial_line;
    logic gie;
    logic rx_irq;
    logic pin_override;
    logic ce;
    logic [15:0] seed;
    int err_total = 0;
    int n_checks = 0;

    // 50 MHz clock
    always #10 clock = ~clock;

    uart_rx_buffer #(.CLKS_PER_BIT(8), .DEPTH(2)) i_dut (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .serial_input_pin(serial_line),
        .global_irq_enable(gie),
        .rx_irq(rx_irq),
        .pin_override(pin_override)
    );

    uart_tx_model #(.CLKS(8)) i_tx (
        .clock(clock),
        .line(serial_line)
    );

    ////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Status word expected in A for an unread head frame
    function automatic logic [8:0] status_word(input logic fe, input logic dor, input logic pe);
        logic [8:0] w;
        w = 9'h000;
        w[`CSA_RXC_BIT] = 1'b1;
        w[`CSA_FE_BIT] = fe;
        w[`CSA_DOR_BIT] = dor;
        w[`CSA_PE_BIT] = pe;
        return w;
    endfunction

    // Status, then ninth bit, then data of the head frame
    task automatic expect_frame(input logic [8:0] d, input logic fe, input logic dor, input logic pe);
        logic [7:0] v;
        rd_reg(`ADDR_CSA, v);
        check("status", {1'b0, v & 8'h9c}, status_word(fe, dor, pe));
        rd_reg(`ADDR_CSB, v);
        check("ninth", {8'h00, v[`CSB_RX9_BIT]}, {8'h00, d[8]});
        rd_reg(`ADDR_DATA, v);
        check("data", {1'b0, v}, {1'b0, d[7:0]});
    endtask

    task automatic expect_empty();
        logic [7:0] v;
        rd_reg(`ADDR_CSA, v);
        check("empty", {1'b0, v & 8'h9c}, 9'h000);
    endtask

    ////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        test_done();
    end

    // Main sequence
    initial begin
        logic [7:0] v;
        logic [8:0] d;
        logic [8:0] q [4];
        logic [2:0] code;
        int n;
        logic pen;
        logic bad;
        rst_b = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        gie = 1'b1;
        ce = 1'b1;
        seed = 16'h4ed7;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check("irq", {8'h00, rx_irq}, 9'h000);
        check("pin", {8'h00, pin_override}, 9'h000);
        rd_reg(`ADDR_CSB, v);
        check("csb", {1'b0, v}, 9'h000);
        rd_reg(`ADDR_CSC, v);
        check("csc", {1'b0, v}, 9'h003);
        expect_empty();
        wr_reg(`ADDR_CSB, 8'h90);
        @(posedge clock);
        #1;
        check("pin", {8'h00, pin_override}, 9'h001);
        // Every size, parity off and on, bad stop and bad parity
        for (int i = 0; i < 10; i++) begin
            code = (i % 5 == 4) ? `SIZE_NINE : {i >= 5 && i < 8, 2'(i % 5)};
            n = (code == `SIZE_NINE) ? 9 : 5 + i % 5;
            pen = (i >= 5);
            bad = (i == 6 || i == 9);
            seed = lfsr_next(seed);
            d = seed[8:0] & ((9'h1 << n) - 9'h1);
            wr_reg(`ADDR_CSC, {2'h0, pen, i[0], i[1], code});
            gie <= (i != 4);
            i_tx.send(d, n, pen, (^d) ^ i[0] ^ bad, i != 3);
            repeat (6) @(posedge clock);
            #1;
            check("irq", {8'h00, rx_irq}, {8'h00, i != 4});
            if (i == 0) begin
                // A data read while the clock enable is low is ignored
                @(posedge clock);
                ce <= 1'b0;
                rd_reg(`ADDR_DATA, v);
                check("frozen", {1'b0, v}, 9'h000);
                @(posedge clock);
                ce <= 1'b1;
            end
            if (i == 9) begin
                wr_reg(`ADDR_CSC, 8'h03);
            end
            expect_frame(d, i == 3, 1'b0, bad && i != 9);
            expect_empty();
            check("irq", {8'h00, rx_irq}, 9'h000);
        end
        // Four frames unread: third held, fourth lost
        wr_reg(`ADDR_CSB, 8'h10);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr_next(seed);
            q[k] = {1'b0, seed[7:0]};
            i_tx.send(q[k], 8, 1'b0, 1'b0, 1'b1);
        end
        repeat (6) @(posedge clock);
        #1;
        check("irq", {8'h00, rx_irq}, 9'h000);
        expect_frame(q[0], 1'b0, 1'b0, 1'b0);
        expect_frame(q[1], 1'b0, 1'b0, 1'b0);
        wr_reg(`ADDR_CSA, 8'h00);
        expect_frame(q[2], 1'b0, 1'b1, 1'b0);
        expect_empty();
        i_tx.send(q[3], 8, 1'b0, 1'b0, 1'b1);
        repeat (6) @(posedge clock);
        expect_frame(q[3], 1'b0, 1'b0, 1'b0);
        // Disable with one stored frame and one in flight
        i_tx.send(q[0], 8, 1'b0, 1'b0, 1'b1);
        fork
            i_tx.send(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
            begin
                repeat (40) @(posedge clock);
                wr_reg(`ADDR_CSB, 8'h00);
                @(posedge clock);
                #1;
                check("pin", {8'h00, pin_override}, 9'h000);
                expect_empty();
            end
        join
        wr_reg(`ADDR_CSB, 8'h10);
        repeat (6) @(posedge clock);
        expect_empty();
        i_tx.send(q[1], 8, 1'b0, 1'b0, 1'b1);
        repeat (6) @(posedge clock);
        expect_frame(q[1], 1'b0, 1'b0, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
